// ==== pfh_regs.vh ====
`ifndef PFH_REGS_VH
`define PFH_REGS_VH

// AXI4-Lite register offsets (byte addresses)
`define PFH_REG_CTRL 4'h0
`define PFH_REG_ADDR 4'h4
`define PFH_REG_WDATA 4'h8
`define PFH_REG_RDATA 4'hc

// CTRL fields
`define PFH_CTRL_GO 0
`define PFH_CTRL_WRITE 1
`define PFH_CTRL_PAGE 2
`define PFH_CTRL_WORD 3
`define PFH_CTRL_BOOST 4
`define PFH_CTRL_RESET 5
`define PFH_CTRL_BUSY 8
`define PFH_CTRL_BOOSTERR 9

// Access timing in ns
`define PFH_T_RANDOM_NS 90
`define PFH_T_PAGE_NS 25
`define PFH_T_WRPULSE_NS 35
`define PFH_T_RECOVER_NS 20
`define PFH_T_RESET_NS 500
`define PFH_CLK_NS 40

`define PFH_AXI_OKAY 2'h0
`define PFH_AXI_SLVERR 2'h2

`endif

// ==== pfh_timer.v ====
`timescale 1ns/100ps
module pfh_timer #(
    parameter W = 8
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire load_i,
    input wire [W-1:0] count_i,
    output wire done_o
);
    reg [W-1:0] cnt_q;
    reg [W-1:0] cnt_d;

    always @* begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = count_i;
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= {W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Done ignores load, so a caller may reload in its done cycle without a loop
    assign done_o = (cnt_q == {W{1'b0}});
endmodule // pfh_timer

// ==== pfh_flash_host.v ====
`timescale 1ns/100ps
`include "pfh_regs.vh"
module pfh_flash_host #(
    parameter AW = 22
) (
    input wire MCLK_I,
    input wire RESET_N_I,
    input wire [3:0] S_AXI_AWADDR_I,
    input wire S_AXI_AWVALID_I,
    output wire S_AXI_AWREADY_O,
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output wire S_AXI_WREADY_O,
    output reg [1:0] S_AXI_BRESP_O,
    output reg S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    input wire [3:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    output wire S_AXI_ARREADY_O,
    output reg [31:0] S_AXI_RDATA_O,
    output reg [1:0] S_AXI_RRESP_O,
    output reg S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    output reg [AW-1:0] FL_ADDR_O,
    input wire [15:0] FL_DQ_I,
    output reg [15:0] FL_DQ_O,
    output reg FL_DQ_OE_O,
    output reg FL_CHIP_SEL_N_O,
    output reg FL_OUT_EN_N_O,
    output reg FL_WRITE_EN_N_O,
    output reg FL_RESTART_N_O,
    output reg FL_WORD_MODE_O,
    output reg FL_PROGRAM_BOOST_O
);
    // Rounded up in integer, then cut to the timer width on purpose
    localparam integer CYC_RANDOM_INT = (`PFH_T_RANDOM_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS;
    localparam integer CYC_PAGE_INT = (`PFH_T_PAGE_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS;
    localparam integer CYC_WRPULSE_INT = (`PFH_T_WRPULSE_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS;
    localparam integer CYC_RECOVER_INT = (`PFH_T_RECOVER_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS;
    localparam integer CYC_RESET_INT = (`PFH_T_RESET_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS;
    localparam [7:0] CYC_RANDOM = CYC_RANDOM_INT[7:0];
    localparam [7:0] CYC_PAGE = CYC_PAGE_INT[7:0];
    localparam [7:0] CYC_WRPULSE = CYC_WRPULSE_INT[7:0];
    localparam [7:0] CYC_RECOVER = CYC_RECOVER_INT[7:0];
    localparam [7:0] CYC_RESET = CYC_RESET_INT[7:0];

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_READ = 3'h1;
    localparam [2:0] ST_WRITE = 3'h2;
    localparam [2:0] ST_RECOVER = 3'h3;
    localparam [2:0] ST_RESET = 3'h4;

    reg [2:0] st_q;
    reg [31:0] addr_q;
    reg [15:0] wdata_q;
    reg [15:0] rdata_q;
    reg word_q;
    reg boost_q;
    reg boost_err_q;
    reg page_ok_q;
    reg [AW-1:0] page_base_q;
    reg go_q;
    reg go_write_q;
    reg go_page_q;
    reg go_reset_q;
    reg aw_got_q;
    reg w_got_q;
    reg [3:0] awaddr_q;
    reg [31:0] wd_q;
    reg tmr_load;
    reg [7:0] tmr_count;
    wire tmr_done;
    wire busy = (st_q != ST_IDLE) || go_q;
    // The new address decides, not the one still on the pins
    wire same_page = page_ok_q && (addr_q[AW-1:2] == page_base_q[AW-1:2]);

    pfh_timer #(.W(8)) u_timer (
        .clk_i(MCLK_I),
        .rst_n_i(RESET_N_I),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    assign S_AXI_AWREADY_O = !aw_got_q && !S_AXI_BVALID_O;
    assign S_AXI_WREADY_O = !w_got_q && !S_AXI_BVALID_O;
    assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

    always @* begin
        tmr_load = 1'b0;
        tmr_count = CYC_RANDOM;
        case (st_q)
            ST_IDLE: begin
                if (go_q) begin
                    tmr_load = 1'b1;
                    if (go_reset_q) begin
                        tmr_count = CYC_RESET;
                    end else if (go_write_q) begin
                        tmr_count = CYC_WRPULSE;
                    end else if (go_page_q && same_page && !FL_CHIP_SEL_N_O) begin
                        tmr_count = CYC_PAGE;
                    end else begin
                        tmr_count = CYC_RANDOM;
                    end
                end
            end
            ST_WRITE: begin
                tmr_load = tmr_done;
                tmr_count = CYC_RECOVER;
            end
            default: begin
                tmr_load = 1'b0;
            end
        endcase
    end

    always @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wd_q <= 32'h0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= `PFH_AXI_OKAY;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RRESP_O <= `PFH_AXI_OKAY;
            S_AXI_RDATA_O <= 32'h0;
            addr_q <= 32'h0;
            wdata_q <= 16'h0;
            word_q <= 1'b1;
            boost_q <= 1'b0;
            go_q <= 1'b0;
            go_write_q <= 1'b0;
            go_page_q <= 1'b0;
            go_reset_q <= 1'b0;
            boost_err_q <= 1'b0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_got_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_got_q <= 1'b1;
                wd_q <= S_AXI_WDATA_I;
            end
            if (st_q == ST_IDLE && go_q) begin
                go_q <= 1'b0;
            end
            if (aw_got_q && w_got_q) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= `PFH_AXI_OKAY;
                case (awaddr_q)
                    `PFH_REG_CTRL: begin
                        if (busy) begin
                            S_AXI_BRESP_O <= `PFH_AXI_SLVERR;
                        end else begin
                            word_q <= wd_q[`PFH_CTRL_WORD];
                            boost_q <= wd_q[`PFH_CTRL_BOOST];
                            if (wd_q[`PFH_CTRL_WRITE] && wd_q[`PFH_CTRL_BOOST] == 1'b0) begin
                                boost_err_q <= 1'b0;
                            end
                            if (wd_q[`PFH_CTRL_BOOST] && !wd_q[`PFH_CTRL_WRITE]) begin
                                boost_err_q <= 1'b1;
                                boost_q <= 1'b0;
                            end
                            go_q <= wd_q[`PFH_CTRL_GO] | wd_q[`PFH_CTRL_RESET];
                            go_write_q <= wd_q[`PFH_CTRL_WRITE];
                            go_page_q <= wd_q[`PFH_CTRL_PAGE];
                            go_reset_q <= wd_q[`PFH_CTRL_RESET];
                        end
                    end
                    `PFH_REG_ADDR: begin
                        addr_q <= wd_q;
                    end
                    `PFH_REG_WDATA: begin
                        wdata_q <= wd_q[15:0];
                    end
                    `PFH_REG_RDATA: begin
                        S_AXI_BRESP_O <= `PFH_AXI_OKAY;
                    end
                    default: begin
                        S_AXI_BRESP_O <= `PFH_AXI_SLVERR;
                    end
                endcase
            end
            if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RRESP_O <= `PFH_AXI_OKAY;
                case (S_AXI_ARADDR_I)
                    `PFH_REG_CTRL: begin
                        S_AXI_RDATA_O <= {22'h0, boost_err_q, busy, 3'h0, boost_q, word_q, 3'h0};
                    end
                    `PFH_REG_ADDR: begin
                        S_AXI_RDATA_O <= addr_q;
                    end
                    `PFH_REG_WDATA: begin
                        S_AXI_RDATA_O <= {16'h0, wdata_q};
                    end
                    `PFH_REG_RDATA: begin
                        S_AXI_RDATA_O <= {16'h0, rdata_q};
                    end
                    default: begin
                        S_AXI_RDATA_O <= 32'h0;
                        S_AXI_RRESP_O <= `PFH_AXI_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // Flash bus sequencing
    always @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st_q <= ST_IDLE;
            FL_ADDR_O <= {AW{1'b0}};
            FL_DQ_O <= 16'h0;
            FL_DQ_OE_O <= 1'b0;
            FL_CHIP_SEL_N_O <= 1'b1;
            FL_OUT_EN_N_O <= 1'b1;
            FL_WRITE_EN_N_O <= 1'b1;
            FL_RESTART_N_O <= 1'b0;
            FL_WORD_MODE_O <= 1'b1;
            FL_PROGRAM_BOOST_O <= 1'b0;
            rdata_q <= 16'h0;
            page_ok_q <= 1'b0;
            page_base_q <= {AW{1'b0}};
        end else begin
            FL_WORD_MODE_O <= word_q;
            case (st_q)
                ST_IDLE: begin
                    FL_RESTART_N_O <= 1'b1;
                    if (go_q) begin
                        FL_ADDR_O <= addr_q[AW-1:0];
                        if (go_reset_q) begin
                            FL_RESTART_N_O <= 1'b0;
                            FL_CHIP_SEL_N_O <= 1'b1;
                            FL_OUT_EN_N_O <= 1'b1;
                            page_ok_q <= 1'b0;
                            st_q <= ST_RESET;
                        end else if (go_write_q) begin
                            FL_CHIP_SEL_N_O <= 1'b0;
                            FL_OUT_EN_N_O <= 1'b1;
                            FL_WRITE_EN_N_O <= 1'b0;
                            FL_DQ_O <= word_q ? wdata_q : {8'h00, wdata_q[7:0]};
                            FL_DQ_OE_O <= 1'b1;
                            FL_PROGRAM_BOOST_O <= boost_q;
                            page_ok_q <= 1'b0;
                            st_q <= ST_WRITE;
                        end else begin
                            FL_CHIP_SEL_N_O <= 1'b0;
                            FL_OUT_EN_N_O <= 1'b0;
                            FL_WRITE_EN_N_O <= 1'b1;
                            FL_DQ_OE_O <= 1'b0;
                            st_q <= ST_READ;
                        end
                    end
                end
                ST_READ: begin
                    if (tmr_done) begin
                        rdata_q <= word_q ? FL_DQ_I : {8'h00, FL_DQ_I[7:0]};
                        page_base_q <= FL_ADDR_O;
                        page_ok_q <= go_page_q;
                        // Page mode keeps select low so the next same-page access stays fast
                        if (!go_page_q) begin
                            FL_CHIP_SEL_N_O <= 1'b1;
                            FL_OUT_EN_N_O <= 1'b1;
                        end
                        st_q <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    if (tmr_done) begin
                        FL_WRITE_EN_N_O <= 1'b1;
                        FL_CHIP_SEL_N_O <= 1'b1;
                        st_q <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    if (tmr_done) begin
                        FL_DQ_OE_O <= 1'b0;
                        FL_PROGRAM_BOOST_O <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
                ST_RESET: begin
                    if (tmr_done) begin
                        FL_RESTART_N_O <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // pfh_flash_host

// ==== pfh_flash_host_assertions.sv ====
`timescale 1ns/100ps
module pfh_flash_host_chk #(
    parameter AW = 22
) (
    input logic MCLK_I,
    input logic RESET_N_I,
    input logic [AW-1:0] FL_ADDR_O,
    input logic [15:0] FL_DQ_O,
    input logic FL_DQ_OE_O,
    input logic FL_CHIP_SEL_N_O,
    input logic FL_OUT_EN_N_O,
    input logic FL_WRITE_EN_N_O,
    input logic FL_RESTART_N_O,
    input logic FL_WORD_MODE_O,
    input logic FL_PROGRAM_BOOST_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    AST_READ_LEVELS: assert property (
        !FL_OUT_EN_N_O |-> !FL_CHIP_SEL_N_O && FL_WRITE_EN_N_O && !FL_DQ_OE_O)
        else $error("read strobe with wrong control levels");
    AST_WRITE_LEVELS: assert property (
        !FL_WRITE_EN_N_O |-> !FL_CHIP_SEL_N_O && FL_OUT_EN_N_O && FL_DQ_OE_O)
        else $error("write strobe with wrong control levels");
    AST_WRITE_PULSE: assert property (
        $fell(FL_WRITE_EN_N_O) |=> !FL_WRITE_EN_N_O && $stable(FL_DQ_O)
            ##1 $rose(FL_WRITE_EN_N_O) && FL_DQ_OE_O && $stable(FL_DQ_O))
        else $error("write pulse length or data hold wrong");
    AST_RANDOM_ACCESS: assert property (
        $fell(FL_CHIP_SEL_N_O) && !FL_OUT_EN_N_O |=> (!FL_CHIP_SEL_N_O && !FL_OUT_EN_N_O && $stable(FL_ADDR_O))[*2])
        else $error("fresh read shorter than the random access time");
    AST_PAGE_CAPTURE: assert property (
        $changed(FL_ADDR_O) && !FL_OUT_EN_N_O && !$past(FL_OUT_EN_N_O) |=> !FL_OUT_EN_N_O)
        else $error("page access ended in the cycle of its address change");
    AST_RESTART_PULSE: assert property (
        $fell(FL_RESTART_N_O) |=> !FL_RESTART_N_O[*8])
        else $error("restart pulse too short");
    AST_RESTART_QUIET: assert property (
        !FL_RESTART_N_O |-> FL_CHIP_SEL_N_O && FL_WRITE_EN_N_O && !FL_DQ_OE_O)
        else $error("bus activity during restart");
    AST_BOOST_NO_READ: assert property (
        FL_PROGRAM_BOOST_O |-> FL_OUT_EN_N_O && FL_RESTART_N_O)
        else $error("boost voltage outside programming");
    AST_WIDTH_STABLE: assert property (
        !FL_CHIP_SEL_N_O && !$past(FL_CHIP_SEL_N_O) |-> $stable(FL_WORD_MODE_O))
        else $error("width select changed while selected");
    COV_READ: cover property ($fell(FL_CHIP_SEL_N_O) && !FL_OUT_EN_N_O);
    COV_WRITE: cover property ($fell(FL_WRITE_EN_N_O));
    COV_RESTART: cover property ($fell(FL_RESTART_N_O));
    COV_BOOST: cover property ($fell(FL_WRITE_EN_N_O) && FL_PROGRAM_BOOST_O);
endmodule // pfh_flash_host_chk

bind pfh_flash_host pfh_flash_host_chk #(.AW(AW)) u_chk (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
    .FL_ADDR_O(FL_ADDR_O), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_O(FL_DQ_OE_O), .FL_CHIP_SEL_N_O(FL_CHIP_SEL_N_O),
    .FL_OUT_EN_N_O(FL_OUT_EN_N_O), .FL_WRITE_EN_N_O(FL_WRITE_EN_N_O), .FL_RESTART_N_O(FL_RESTART_N_O),
    .FL_WORD_MODE_O(FL_WORD_MODE_O), .FL_PROGRAM_BOOST_O(FL_PROGRAM_BOOST_O));

// ==== pfh_flash_model.sv ====
`timescale 1ns/100ps
module pfh_flash_model #(
    parameter AW = 22,
    parameter real T_RAND_NS = 90.0,
    parameter real T_PAGE_NS = 25.0
) (
    input wire [AW-1:0] addr_i,
    input wire [15:0] dq_i,
    input wire dq_oe_i,
    input wire chip_sel_n_i,
    input wire out_en_n_i,
    input wire write_en_n_i,
    input wire restart_n_i,
    input wire word_mode_i,
    input wire program_boost_i,
    output logic [15:0] dq_o
);
    logic [15:0] mem [0:63];
    logic [15:0] last_q = 16'h0;
    wire [AW-1:0] pa = word_mode_i ? addr_i : addr_i >> 1;
    wire [15:0] wd = mem[pa[5:0]];
    wire sel = !chip_sel_n_i && !out_en_n_i && write_en_n_i && restart_n_i && !program_boost_i;
    wire sel_dly;
    wire [AW-1:0] page_dly;
    wire [2:0] low_dly;
    wire ready;
    // Inertial delays give access times; stable address keeps data
    assign #(T_RAND_NS) sel_dly = sel;
    assign #(T_RAND_NS) page_dly = pa >> 2;
    assign #(T_PAGE_NS) low_dly = {pa[1:0], addr_i[0]};
    assign ready = sel && sel_dly && page_dly == (pa >> 2) && low_dly == {pa[1:0], addr_i[0]};
    initial for (int k = 0; k < 64; k++) mem[k] = 16'ha500 ^ 16'(k);
    // Byte lane pick, upper lanes keep the inverse of last_q
    always @* begin
        dq_o = ~last_q;
        if (ready && word_mode_i) dq_o = wd;
        if (ready && !word_mode_i) dq_o[7:0] = addr_i[0] ? wd[15:8] : wd[7:0];
    end
    // Released bus shows the inverse, never a stale copy
    always @(dq_o) begin
        if (ready) last_q[7:0] = dq_o[7:0];
        if (ready && word_mode_i) last_q[15:8] = dq_o[15:8];
    end
    // Strobe alters the array once; a later deselect cannot undo it
    // Settling delay keeps same-step pin updates from writing a stale address
    always @(negedge write_en_n_i) begin
        #1;
        if (!write_en_n_i && !chip_sel_n_i && restart_n_i && dq_oe_i && word_mode_i) mem[pa[5:0]] = dq_i;
    end
endmodule // pfh_flash_model

// ==== pfh_tb.sv ====
`timescale 1ns/100ps
`include "pfh_regs.vh"
module tb;
    localparam logic [31:0] GO = 32'h1 << `PFH_CTRL_GO;
    localparam logic [31:0] WR = 32'h1 << `PFH_CTRL_WRITE;
    localparam logic [31:0] PG = 32'h1 << `PFH_CTRL_PAGE;
    localparam logic [31:0] WD = 32'h1 << `PFH_CTRL_WORD;
    localparam logic [31:0] BS = 32'h1 << `PFH_CTRL_BOOST;
    localparam logic [31:0] RS = 32'h1 << `PFH_CTRL_RESET;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic dq_oe, cs_n, oe_n, we_n, fl_rst_n, word, boost;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp;
    logic [21:0] fl_addr;
    logic [15:0] fl_dq, mdl_dq, v;
    logic [15:0] shadow [0:63];
    logic [1:0] exp_b [$];
    logic [65:0] exp_r [$];
    logic [5:0] a;
    int err_count, checked, i;
    wire [15:0] dq_bus = dq_oe ? fl_dq : mdl_dq;
    pfh_flash_host #(.AW(22)) uut (.MCLK_I(clk), .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .FL_ADDR_O(fl_addr), .FL_DQ_I(dq_bus), .FL_DQ_O(fl_dq), .FL_DQ_OE_O(dq_oe), .FL_CHIP_SEL_N_O(cs_n),
        .FL_OUT_EN_N_O(oe_n), .FL_WRITE_EN_N_O(we_n), .FL_RESTART_N_O(fl_rst_n), .FL_WORD_MODE_O(word),
        .FL_PROGRAM_BOOST_O(boost));
    pfh_flash_model #(.AW(22)) u_mdl (.addr_i(fl_addr), .dq_i(dq_bus), .dq_oe_i(dq_oe), .chip_sel_n_i(cs_n),
        .out_en_n_i(oe_n), .write_en_n_i(we_n), .restart_n_i(fl_rst_n), .word_mode_i(word),
        .program_boost_i(boost), .dq_o(mdl_dq));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Handshakes are judged half a cycle early, where nothing is moving
    always @(negedge clk) begin
        if (bvalid && bready) begin
            checked++;
            if (bresp !== exp_b[0]) begin
                err_count++;
                $display("unexpected bresp: expected %h seen %h", exp_b[0], bresp);
            end
            void'(exp_b.pop_front());
        end
        if (rvalid && rready) begin
            checked++;
            if (rresp !== exp_r[0][65:64]) begin
                err_count++;
                $display("unexpected rresp: expected %h seen %h", exp_r[0][65:64], rresp);
            end
            if (exp_r[0][63:32] != 32'h0) checked++;
            if ((rdata & exp_r[0][63:32]) !== exp_r[0][31:0]) begin
                err_count++;
                $display("unexpected rdata: expected %h seen %h", exp_r[0][31:0], rdata & exp_r[0][63:32]);
            end
            void'(exp_r.pop_front());
        end
    end
    task automatic axi_wr(input logic [3:0] ad, input logic [31:0] dt, input logic [1:0] er);
        logic ha, hw, hb;
        // One edge between transfers, so no strobe is assigned twice in a step
        @(posedge clk);
        exp_b.push_back(er);
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
    endtask
    task automatic axi_rd(input logic [3:0] ad, input logic [31:0] ex, input logic [31:0] mk,
        input logic [1:0] er = `PFH_AXI_OKAY);
        logic ha, hr;
        @(posedge clk);
        exp_r.push_back({er, mk, ex & mk});
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge clk);
            ha = arvalid && arready;
            hr = rvalid && rready;
            if (hr) d = rdata;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
        end
    endtask
    task automatic wait_idle();
        d[`PFH_CTRL_BUSY] = 1'b1;
        while (d[`PFH_CTRL_BUSY] !== 1'b0) axi_rd(`PFH_REG_CTRL, 32'h0, 32'h0);
    endtask
    task automatic flash_op(input logic [21:0] ad, input logic [15:0] dt, input logic [31:0] c);
        axi_wr(`PFH_REG_ADDR, {10'h0, ad}, `PFH_AXI_OKAY);
        axi_wr(`PFH_REG_WDATA, {16'h0, dt}, `PFH_AXI_OKAY);
        axi_wr(`PFH_REG_CTRL, c, `PFH_AXI_OKAY);
        wait_idle();
    endtask
    task automatic rd_flash(input logic [21:0] ad, input logic [31:0] c, input logic [31:0] ex, input logic [31:0] mk);
        flash_op(ad, 16'h0, c);
        axi_rd(`PFH_REG_RDATA, ex, mk);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        for (i = 0; i < 64; i++) shadow[i] = 16'ha500 ^ 16'(i);
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        void'($urandom(79));
        @(posedge clk);
        axi_rd(`PFH_REG_CTRL, WD, 32'h318);
        axi_wr(4'h2, 32'h0, `PFH_AXI_SLVERR);
        axi_rd(4'h2, 32'h0, 32'h0, `PFH_AXI_SLVERR);
        rd_flash(22'h5, GO | WD, {16'h0, shadow[5]}, 32'hffff);
        for (i = 0; i < 6; i++) begin
            a = 6'($urandom);
            v = 16'($urandom);
            flash_op({16'h0, a}, v, GO | WR | WD);
            shadow[a] = v;
            rd_flash({16'h0, a}, GO | WD, {16'h0, v}, 32'hffff);
        end
        // Sweep crosses a page boundary with the chip kept selected
        for (i = 0; i < 8; i++) begin
            rd_flash(22'(16 + i), (i < 7) ? (GO | WD | PG) : (GO | WD),
                {16'h0, shadow[16 + i]}, 32'hffff);
        end
        for (i = 0; i < 4; i++) begin
            v = shadow[8 + i / 2];
            rd_flash(22'(16 + i), GO, 32'(i[0] ? v[15:8] : v[7:0]), 32'hff);
        end
        flash_op(22'h3, 16'h0, GO | BS | WD);
        axi_rd(`PFH_REG_CTRL, 32'h200, 32'h200);
        v = 16'($urandom);
        flash_op(22'h9, v, GO | WR | BS | WD);
        rd_flash(22'h9, GO | WD, {16'h0, v}, 32'hffff);
        axi_wr(`PFH_REG_CTRL, GO | RS | WD, `PFH_AXI_OKAY);
        axi_wr(`PFH_REG_CTRL, GO | WD, `PFH_AXI_SLVERR);
        wait_idle();
        flash_op(22'h9, 16'h0, WD);
        rd_flash(22'h9, GO | WD, {16'h0, v}, 32'hffff);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end
endmodule // tb
